/* ibc_core.sv */
// instruction-unit control/status register, translation holding register
// and the two performance counters with delayed overflow requests
// assumes single clk domain; external_count_pin is asynchronous
//
// Summary of operation
// - store space number on fills; fetch mismatch kills fetch, line untouched
// - float enable set lets float issue; clear faults every float instruction
// - kernel superpage fetch with vpc 42:41 = 2 maps 33:13 directly, global set
// - hw enable lets reserved privileged instructions issue in kernel mode (always in pal); else illegal opcode
// - dual issue only while dual issue enable set
// - prediction: off not taken, history off sign, both on history table
// - return stack pushes only while its enable bit set
// - pipe bit clear: interlocked instruction drains until write buffer and pipe empty
// - counter 1 event chosen by three-bit select, reset zero
// - counter 0 event chosen by four-bit select, reset zero
// - counter 1 overflows at 2^12 events, or 2^8 with threshold set
// - counter 0 overflows at 2^16 events, or 2^12 with threshold set
// - counters zeroed at power-up only, never readable
// - counters run always, whatever the interrupt enables
// - overflow request appears six cycles after event; later events count on
// - request lost only when counter overflows again before service
// - icache-miss counting blocks completion until request; keeps miss pc
// - aborted and reissued events may count once per attempt
// - external select counts pin sampled at fixed clock interval: high for counter 1, low for counter 0
// - translation data read in two steps through the holding register
// - holding register reloaded on every translation buffer access
// - reset clears control bits; space number and thresholds undefined
`timescale 1ns/1ps
`include "ibc_defines.svh"
module ibc_core #(
  parameter int unsigned EXT_SAMPLE_CYCLES = 8
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire ibc_pkg::ibc_ipr_req_t ipr_req,
  input  wire logic                  itb_access,
  input  wire logic [63:0]           instr_xlate_entry,
  input  wire ibc_pkg::ibc_dec_t     dec,
  input  wire ibc_pkg::ibc_evt_t     evt,
  input  wire logic                  external_count_pin,
  input  wire logic                  kernel_mode,
  input  wire logic                  pal_mode,
  input  wire logic                  fetch_valid,
  input  wire logic [42:0]           fetch_vpc,
  input  wire logic [5:0]            line_space,
  input  wire logic                  wb_empty,
  input  wire logic                  pipe_empty,
  input  wire logic [1:0]            irq_ack,
  output logic [63:0]                ipr_rdata_r,
  output logic                       ipr_rvalid_r,
  output ibc_pkg::ibc_ctl_t          ctl_r,
  output logic [20:0]                spage_pa_r,
  output logic [5:0]                 fill_space_r,
  output logic [42:0]                miss_pc_r,
  output logic [1:0]                 irq_r
);

  ibc_pkg::ibc_state_t s_r;
  ibc_pkg::ibc_state_t s_nxt;
  logic [1:0]          amt0;
  logic [1:0]          acc0;
  logic                inc0;
  logic                inc1;
  logic                ov0;
  logic                ov1;
  logic                tick;
  logic                drain_go;

  // true when the low k bits are all ones, so one more event wraps them
  function automatic logic ovf_at(input logic [15:0] c, input int unsigned k);
    logic [15:0] m;
    m = 16'((32'h1 << k) - 32'h1);
    return (c & m) == m;
  endfunction

  // counter 0 increment in half units, so the /2 selections need no divider
  function automatic logic [1:0] half_units(
    input logic [3:0]        sel,
    input ibc_pkg::ibc_evt_t e,
    input logic              pal,
    input logic              ext0
  );
    logic [1:0] a;
    a = 2'h0;
    casez (sel)
      `IBC_M0_ISSUE:  a = e.issue_cnt;
      `IBC_M0_DRY:    a = {e.pipe_dry, 1'b0};
      `IBC_M0_LOAD:   a = {e.load, 1'b0};
      `IBC_M0_FROZEN: a = {e.frozen, 1'b0};
      `IBC_M0_BRANCH: a = {e.branch, 1'b0};
      `IBC_M0_PAL:    a = {pal, 1'b0};
      `IBC_M0_CYCLES: a = 2'h2;
      `IBC_M0_NOISS:  a = 2'h2 - e.issue_cnt;
      `IBC_M0_EXT:    a = {ext0, 1'b0};
      default:        a = 2'h0;
    endcase
    return a;
  endfunction

  function automatic logic sel1_event(
    input ibc_pkg::ibc_sel1_t sel,
    input ibc_pkg::ibc_evt_t  e,
    input logic               ext1
  );
    logic v;
    v = 1'b0;
    case (sel)
      ibc_pkg::IBC_M1_DC_MISS: v = e.dcache_miss;
      ibc_pkg::IBC_M1_IC_MISS: v = e.icache_miss;
      ibc_pkg::IBC_M1_DUAL:    v = e.dual_issue;
      ibc_pkg::IBC_M1_MISPRED: v = e.br_mispredict;
      ibc_pkg::IBC_M1_FLOAT:   v = e.fp_op;
      ibc_pkg::IBC_M1_INT:     v = e.int_op;
      ibc_pkg::IBC_M1_STORE:   v = e.store;
      ibc_pkg::IBC_M1_EXT:     v = ext1;
      default:                 v = 1'b0;
    endcase
    return v;
  endfunction

  // fields stand at read-format positions, all other bits read zero
  function automatic logic [63:0] read_fmt(input ibc_pkg::ibc_csr_t c);
    logic [63:0] v;
    v = 64'h0;
    v[`IBC_R_SPACE +: 6] = c.addr_space_number;
    v[`IBC_R_FLT]        = c.float_enable;
    v[`IBC_R_MAP]        = c.map_enable;
    v[`IBC_R_HWI]        = c.hw_instr_enable;
    v[`IBC_R_DUAL]       = c.dual_issue_enable;
    v[`IBC_R_HIST]       = c.branch_history_enable;
    v[`IBC_R_RSTK]       = c.return_stack_enable;
    v[`IBC_R_PRED]       = c.branch_predict_enable;
    v[`IBC_R_SEL1 +: 3]  = c.counter1_select;
    v[`IBC_R_SEL0 +: 4]  = c.counter0_select;
    v[`IBC_R_THR1]       = c.counter1_threshold;
    v[`IBC_R_THR0]       = c.counter0_threshold;
    return v;
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    // register port: writes take write-format positions
    if (ipr_req.wr && ipr_req.index == `IBC_IDX_CSR)
    begin
      s_nxt.csr.addr_space_number     = ipr_req.wdata[`IBC_W_SPACE +: 6];
      s_nxt.csr.float_enable          = ipr_req.wdata[`IBC_W_FLT];
      s_nxt.csr.map_enable            = ipr_req.wdata[`IBC_W_MAP];
      s_nxt.csr.hw_instr_enable       = ipr_req.wdata[`IBC_W_HWI];
      s_nxt.csr.dual_issue_enable     = ipr_req.wdata[`IBC_W_DUAL];
      s_nxt.csr.branch_history_enable = ipr_req.wdata[`IBC_W_HIST];
      s_nxt.csr.return_stack_enable   = ipr_req.wdata[`IBC_W_RSTK];
      s_nxt.csr.branch_predict_enable = ipr_req.wdata[`IBC_W_PRED];
      s_nxt.csr.counter1_select       =
        ibc_pkg::ibc_sel1_t'(ipr_req.wdata[`IBC_W_SEL1 +: 3]);
      s_nxt.csr.counter0_select       = ipr_req.wdata[`IBC_W_SEL0 +: 4];
      s_nxt.csr.counter1_threshold    = ipr_req.wdata[`IBC_W_THR1];
      s_nxt.csr.counter0_threshold    = ipr_req.wdata[`IBC_W_THR0];
    end
    s_nxt.rvalid = ipr_req.rd;
    s_nxt.rdata  = 64'h0;
    if (ipr_req.rd)
    begin
      case (ipr_req.index)
        `IBC_IDX_CSR:  s_nxt.rdata = read_fmt(s_r.csr);
        `IBC_IDX_HOLD: s_nxt.rdata = s_r.hold;
        default:       s_nxt.rdata = 64'h0;
      endcase
    end
    // read or write of the buffer both reload it, so read it right away
    if (itb_access)
      s_nxt.hold = instr_xlate_entry;

    // issue permissions
    s_nxt.ctl.fp_issue_ok          = s_r.csr.float_enable;
    s_nxt.ctl.float_disabled_fault = dec.fp && !s_r.csr.float_enable;
    s_nxt.ctl.reserved_priv_instrs_ok            = pal_mode ||
      (s_r.csr.hw_instr_enable && kernel_mode);
    s_nxt.ctl.illegal_opcode_fault = dec.reserved_priv_instrs && !pal_mode &&
      !(s_r.csr.hw_instr_enable && kernel_mode);
    s_nxt.ctl.dual_ok              = s_r.csr.dual_issue_enable;
    s_nxt.ctl.ras_push_ok          = s_r.csr.return_stack_enable;
    if (!s_r.csr.branch_predict_enable)
      s_nxt.ctl.bp_mode = ibc_pkg::IBC_BP_NOT_TAKEN;
    else if (!s_r.csr.branch_history_enable)
      s_nxt.ctl.bp_mode = ibc_pkg::IBC_BP_SIGN;
    else
      s_nxt.ctl.bp_mode = ibc_pkg::IBC_BP_HISTORY;

    // fetch qualification; the cached line itself is never touched here
    s_nxt.fill_space     = s_r.csr.addr_space_number;
    s_nxt.ctl.fetch_kill = fetch_valid &&
      (line_space != s_r.csr.addr_space_number);
    s_nxt.ctl.spage_hit  = fetch_valid && s_r.csr.map_enable && kernel_mode &&
      (fetch_vpc[42:41] == `IBC_SPAGE_TAG);
    s_nxt.ctl.spage_global = s_nxt.ctl.spage_hit;
    s_nxt.spage_pa       = fetch_vpc[33:13];

    // drain control; the pipe bit shares its position with history enable
    drain_go = dec.interlocked && !dec.exempt && !s_r.csr.branch_history_enable;
    case (s_r.st)
      ibc_pkg::IBC_RUN:
      begin
        if (drain_go)
        begin
          s_nxt.st             = ibc_pkg::IBC_DRAIN;
          s_nxt.ctl.issue_hold = 1'b1;
        end
      end
      ibc_pkg::IBC_DRAIN:
      begin
        if (wb_empty && pipe_empty)
        begin
          s_nxt.st             = ibc_pkg::IBC_RUN;
          s_nxt.ctl.issue_hold = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st             = ibc_pkg::IBC_RUN;
        s_nxt.ctl.issue_hold = 1'b0;
      end
    endcase

    // external pin: synchronised, then sampled once per interval
    s_nxt.ext_s1  = external_count_pin;
    s_nxt.ext_s2  = s_r.ext_s1;
    tick          = s_r.ext_div == 16'(EXT_SAMPLE_CYCLES - 1);
    s_nxt.ext_div = tick ? 16'h0 : s_r.ext_div + 16'h1;

    // counters count whatever is presented, aborted attempts included
    amt0 = half_units(s_r.csr.counter0_select, evt, pal_mode,
                      tick && !s_r.ext_s2);
    acc0 = {1'b0, s_r.half0} + amt0;
    inc0 = acc0[1];
    s_nxt.half0 = acc0[0];
    inc1 = sel1_event(s_r.csr.counter1_select, evt,
                      tick && s_r.ext_s2);
    ov0 = inc0 && ovf_at(s_r.cnt0, s_r.csr.counter0_threshold ?
                         `IBC_C0_SHORT : `IBC_C0_LONG);
    ov1 = inc1 && ovf_at({4'h0, s_r.cnt1}, s_r.csr.counter1_threshold ?
                         `IBC_C1_SHORT : `IBC_C1_LONG);
    // never cleared, so a new selection may overflow early
    s_nxt.cnt0 = s_r.cnt0 + 16'(inc0);
    s_nxt.cnt1 = s_r.cnt1 + 12'(inc1);

    // overflow travels a delay line; request set wins over acknowledge
    s_nxt.sh0 = {s_r.sh0[`IBC_IRQ_DELAY-3:0], ov0};
    s_nxt.sh1 = {s_r.sh1[`IBC_IRQ_DELAY-3:0], ov1};
    // a second overflow before service merges with the pending one
    s_nxt.irq[0] = (s_r.irq[0] && !irq_ack[0]) ||
      s_r.sh0[`IBC_IRQ_DELAY-2];
    s_nxt.irq[1] = (s_r.irq[1] && !irq_ack[1]) ||
      s_r.sh1[`IBC_IRQ_DELAY-2];
    s_nxt.ctl.no_complete =
      (s_r.csr.counter1_select == ibc_pkg::IBC_M1_IC_MISS) &&
      (ov1 || (|s_r.sh1));
    if (evt.icache_miss)
      s_nxt.miss_pc = fetch_vpc;
  end

  // space number and thresholds are undefined after reset; zero is one such value
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ipr_rdata_r  = s_r.rdata;
  assign ipr_rvalid_r = s_r.rvalid;
  assign ctl_r        = s_r.ctl;
  assign spage_pa_r   = s_r.spage_pa;
  assign fill_space_r = s_r.fill_space;
  assign miss_pc_r    = s_r.miss_pc;
  assign irq_r        = s_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_ovf0;
    ov0;
  endsequence
  sequence s_ovf1;
    ov1;
  endsequence
  sequence s_req0_late;
    ##6 irq_r[0];
  endsequence
  sequence s_req1_late;
    ##6 irq_r[1];
  endsequence

  a_irq0_delay: assert property (s_ovf0 |-> s_req0_late)
    else $error("counter 0 request not six cycles after overflow");
  a_irq1_delay: assert property (s_ovf1 |-> s_req1_late)
    else $error("counter 1 request not six cycles after overflow");
  a_irq0_early: assert property (!irq_r[0] && !(|s_r.sh0) && !ov0 |=> !irq_r[0])
    else $error("counter 0 request without overflow");
  a_float_fault: assert property (dec.fp && !s_r.csr.float_enable |=>
      ctl_r.float_disabled_fault)
    else $error("float instruction not faulted while disabled");
  a_illegal_op: assert property (dec.reserved_priv_instrs && !pal_mode &&
      !s_r.csr.hw_instr_enable |=> ctl_r.illegal_opcode_fault && !ctl_r.reserved_priv_instrs_ok)
    else $error("reserved instruction not refused");
  a_spage_map: assert property (fetch_valid && s_r.csr.map_enable && kernel_mode &&
      fetch_vpc[42:41] == `IBC_SPAGE_TAG |=> ctl_r.spage_hit && ctl_r.spage_global &&
      spage_pa_r == $past(fetch_vpc[33:13]))
    else $error("superpage fetch not mapped");
  a_space_kill: assert property (fetch_valid &&
      line_space != s_r.csr.addr_space_number |=> ctl_r.fetch_kill)
    else $error("space mismatch did not kill fetch");
  a_drain_hold: assert property (s_r.st == ibc_pkg::IBC_RUN && drain_go |=>
      ctl_r.issue_hold throughout (!(wb_empty && pipe_empty))[*1])
    else $error("interlocked instruction did not hold issue");
  a_hold_load: assert property (itb_access && !(ipr_req.rd) |=>
      s_r.hold == $past(instr_xlate_entry))
    else $error("holding register not reloaded");
  a_read_fmt: assert property (ipr_req.rd && ipr_req.index == `IBC_IDX_CSR |=>
      ipr_rvalid_r && ipr_rdata_r[`IBC_R_FLT] == $past(s_r.csr.float_enable) &&
      ipr_rdata_r[63:34] == 30'h0)
    else $error("control register read format wrong");
  a_dual_gate: assert property (!s_r.csr.dual_issue_enable ##1
      !s_r.csr.dual_issue_enable |-> !ctl_r.dual_ok)
    else $error("dual issue allowed while disabled");
  a_pred_off: assert property (!s_r.csr.branch_predict_enable |=>
      ctl_r.bp_mode == ibc_pkg::IBC_BP_NOT_TAKEN)
    else $error("prediction not forced not taken");
  a_stack_gate: assert property (!s_r.csr.return_stack_enable |=> !ctl_r.ras_push_ok)
    else $error("return stack enabled while bit clear");

endmodule

/* ibc_defines.svh */
// constants for the instruction-unit control block
// assumes inclusion by ibc_pkg.sv and ibc_core.sv only
`ifndef IBC_DEFINES_SVH
`define IBC_DEFINES_SVH
`define IBC_IDX_CSR    5'h02
`define IBC_IDX_HOLD   5'h03
`define IBC_W_SPACE    47
`define IBC_W_FLT      42
`define IBC_W_MAP      41
`define IBC_W_HWI      40
`define IBC_W_DUAL     39
`define IBC_W_HIST     38
`define IBC_W_RSTK     37
`define IBC_W_PRED     36
`define IBC_W_SEL1     32
`define IBC_W_SEL0     8
`define IBC_W_THR1     0
`define IBC_W_THR0     3
`define IBC_R_SPACE    28
`define IBC_R_FLT      23
`define IBC_R_MAP      22
`define IBC_R_HWI      21
`define IBC_R_DUAL     20
`define IBC_R_HIST     19
`define IBC_R_RSTK     18
`define IBC_R_PRED     17
`define IBC_R_SEL1     13
`define IBC_R_SEL0     9
`define IBC_R_THR1     2
`define IBC_R_THR0     1
`define IBC_SPAGE_TAG  2'h2
`define IBC_C1_SHORT   8
`define IBC_C1_LONG    12
`define IBC_C0_SHORT   12
`define IBC_C0_LONG    16
`define IBC_IRQ_DELAY  6
`define IBC_M0_ISSUE   4'b000?
`define IBC_M0_DRY     4'b001?
`define IBC_M0_LOAD    4'b010?
`define IBC_M0_FROZEN  4'b011?
`define IBC_M0_BRANCH  4'b100?
`define IBC_M0_PAL     4'hB
`define IBC_M0_CYCLES  4'hA
`define IBC_M0_NOISS   4'b110?
`define IBC_M0_EXT     4'b111?
`endif

/* ibc_pkg.sv */
// types for the instruction-unit control block
// assumes ibc_defines.svh is on the include path
`include "ibc_defines.svh"
package ibc_pkg;
  typedef enum logic [2:0] {IBC_M1_DC_MISS, IBC_M1_IC_MISS, IBC_M1_DUAL,
    IBC_M1_MISPRED, IBC_M1_FLOAT, IBC_M1_INT, IBC_M1_STORE, IBC_M1_EXT} ibc_sel1_t;
  typedef enum logic [1:0] {IBC_BP_NOT_TAKEN, IBC_BP_SIGN, IBC_BP_HISTORY} ibc_bp_t;
  typedef enum logic {IBC_RUN, IBC_DRAIN} ibc_st_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  index;
    logic [63:0] wdata;
  } ibc_ipr_req_t;
  typedef struct packed {
    logic fp;
    logic reserved_priv_instrs;
    logic interlocked;
    logic exempt;
  } ibc_dec_t;
  typedef struct packed {
    logic dcache_miss, icache_miss, dual_issue, br_mispredict;
    logic fp_op, int_op, store, pipe_dry, load, frozen, branch;
    logic [1:0] issue_cnt;
  } ibc_evt_t;
  typedef struct packed {
    logic [5:0] addr_space_number;
    logic       float_enable, map_enable, hw_instr_enable, dual_issue_enable;
    logic       branch_history_enable, return_stack_enable, branch_predict_enable;
    ibc_sel1_t  counter1_select;
    logic [3:0] counter0_select;
    logic       counter1_threshold, counter0_threshold;
  } ibc_csr_t;
  typedef struct packed {
    logic    fp_issue_ok, float_disabled_fault, reserved_priv_instrs_ok, illegal_opcode_fault;
    logic    dual_ok, ras_push_ok, issue_hold, fetch_kill;
    logic    spage_hit, spage_global, no_complete;
    ibc_bp_t bp_mode;
  } ibc_ctl_t;
  typedef struct packed {
    ibc_csr_t    csr;
    ibc_ctl_t    ctl;
    ibc_st_t     st;
    logic [15:0] cnt0;
    logic [11:0] cnt1;
    logic        half0;
    logic [`IBC_IRQ_DELAY-2:0] sh0, sh1;
    logic [1:0]  irq;
    logic        ext_s1, ext_s2;
    logic [15:0] ext_div;
    logic [63:0] hold, rdata;
    logic        rvalid;
    logic [20:0] spage_pa;
    logic [5:0]  fill_space;
    logic [42:0] miss_pc;
  } ibc_state_t;
endpackage

/* test_ibox_control_perf_counters.sv */
// self-checking bench for the instruction-unit control block
// assumes ibc_pkg.sv and ibc_core.sv are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); end end
module test_ibox_control_perf_counters;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  ibc_pkg::ibc_ipr_req_t req = '0;
  logic                  itb_acc = 1'b0;
  logic [63:0]           entry = '0;
  ibc_pkg::ibc_dec_t     dec = '0;
  ibc_pkg::ibc_evt_t     evt = '0;
  logic                  ext_pin = 1'b0;
  logic                  kern = 1'b0;
  logic                  pal = 1'b0;
  logic                  fv = 1'b0;
  logic [42:0]           vpc = '0;
  logic [5:0]            lsp = '0;
  logic                  wbe = 1'b1;
  logic                  pe = 1'b1;
  logic [1:0]            ack = '0;
  logic [63:0]           rdata;
  logic                  rvalid;
  ibc_pkg::ibc_ctl_t     ctl;
  logic [20:0]           spa;
  logic [5:0]            fsp;
  logic [42:0]           mpc;
  logic [1:0]            irq;
  logic [63:0]           q;
  int                    err_total = 0;
  int                    total_checks = 0;
  int                    cyc = 0;

  always #5 clk = ~clk;

  // short external sample interval keeps the pin test brief
  ibc_core #(.EXT_SAMPLE_CYCLES(2)) DUT (
    .clk(clk), .arst_n(arst_n), .ipr_req(req), .itb_access(itb_acc),
    .instr_xlate_entry(entry), .dec(dec), .evt(evt), .external_count_pin(ext_pin),
    .kernel_mode(kern), .pal_mode(pal), .fetch_valid(fv), .fetch_vpc(vpc),
    .line_space(lsp), .wb_empty(wbe), .pipe_empty(pe), .irq_ack(ack),
    .ipr_rdata_r(rdata), .ipr_rvalid_r(rvalid), .ctl_r(ctl), .spage_pa_r(spa),
    .fill_space_r(fsp), .miss_pc_r(mpc), .irq_r(irq));

  task give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // longest run is about 17000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      give_verdict;
    end
  end

  function automatic logic [63:0] wf(logic [5:0] a, logic [6:0] b, logic [2:0] s1,
                                     logic [3:0] s0, logic t1, logic t0);
    return (64'(a) << 47) | (64'(b) << 36) | (64'(s1) << 32) | (64'(s0) << 8)
         | 64'(t1) | (64'(t0) << 3);
  endfunction

  function automatic logic [63:0] rf(logic [5:0] a, logic [6:0] b, logic [2:0] s1,
                                     logic [3:0] s0, logic t1, logic t0);
    return (64'(a) << 28) | (64'(b) << 17) | (64'(s1) << 13) | (64'(s0) << 9)
         | (64'(t1) << 2) | (64'(t0) << 1);
  endfunction

  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle request; read data sampled in the answer cycle
  task automatic ipr(input logic wr, input logic [4:0] idx, input logic [63:0] d,
                     output logic [63:0] o);
    @(negedge clk);
    req = '{rd: !wr, wr: wr, index: idx, wdata: d};
    @(negedge clk);
    req = '0;
    o = rdata;
    if (!wr) `CHK("rvalid", 1'b1, rvalid);
  endtask

  task automatic cfg(input logic [5:0] a, input logic [6:0] b, input logic [2:0] s1,
                     input logic [3:0] s0, input logic t1, input logic t0);
    ipr(1'b1, 5'h02, wf(a, b, s1, s0, t1, t0), q);
    wait_n(3);
  endtask

  task t_reset;
    ipr(1'b0, 5'h02, '0, q);
    // space number and thresholds come up undefined
    `CHK("csr_reset", 64'h0, q & ~64'h3F0000006);
    `CHK("bp_reset", ibc_pkg::IBC_BP_NOT_TAKEN, ctl.bp_mode);
    `CHK("irq_reset", 2'h0, irq);
  endtask

  task t_format;
    cfg(6'h2A, 7'h7F, 3'h5, 4'h9, 1'b1, 1'b1);
    ipr(1'b0, 5'h02, '0, q);
    `CHK("csr_read", rf(6'h2A, 7'h7F, 3'h5, 4'h9, 1'b1, 1'b1), q);
    ipr(1'b1, 5'h07, 64'hFFFFFFFFFFFFFFFF, q);
    ipr(1'b0, 5'h07, '0, q);
    `CHK("unmapped", 64'h0, q);
    ipr(1'b0, 5'h02, '0, q);
    `CHK("csr_kept", rf(6'h2A, 7'h7F, 3'h5, 4'h9, 1'b1, 1'b1), q);
  endtask

  task automatic t_enables;
    dec = 4'b1100;
    kern = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      logic [6:0] b;
      b = {i[0], 1'b0, i[0], i[1], i[1], i[0], i[0]};
      cfg(6'h00, b, 3'h0, 4'h0, 1'b0, 1'b0);
      `CHK("fp_ok", logic'(i[0]), ctl.fp_issue_ok);
      `CHK("fp_fault", logic'(!i[0]), ctl.float_disabled_fault);
      `CHK("reserved_priv_instrs_ok", logic'(i[0]), ctl.reserved_priv_instrs_ok);
      `CHK("opc_fault", logic'(!i[0]), ctl.illegal_opcode_fault);
      `CHK("dual_ok", logic'(i[1]), ctl.dual_ok);
      `CHK("ras_ok", logic'(i[0]), ctl.ras_push_ok);
      `CHK("bp_mode", i[0] ? (i[1] ? ibc_pkg::IBC_BP_HISTORY : ibc_pkg::IBC_BP_SIGN)
           : ibc_pkg::IBC_BP_NOT_TAKEN, ctl.bp_mode);
    end
    dec = '0;
  endtask

  task t_fetch;
    cfg(6'h15, 7'h24, 3'h0, 4'h0, 1'b0, 1'b0);
    fv = 1'b1;
    vpc = {2'b10, 7'h00, 21'h1ABCD, 13'h0};
    lsp = 6'h15;
    wait_n(3);
    `CHK("spage_hit", 1'b1, ctl.spage_hit);
    `CHK("spage_glob", 1'b1, ctl.spage_global);
    `CHK("spage_pa", 21'h1ABCD, spa);
    `CHK("kill_match", 1'b0, ctl.fetch_kill);
    `CHK("fill_space", 6'h15, fsp);
    lsp = 6'h16;
    vpc[42:41] = 2'b01;
    wait_n(3);
    `CHK("kill_miss", 1'b1, ctl.fetch_kill);
    `CHK("spage_tag", 1'b0, ctl.spage_hit);
    vpc[42:41] = 2'b10;
    kern = 1'b0;
    wait_n(3);
    `CHK("spage_user", 1'b0, ctl.spage_hit);
    fv = 1'b0;
    kern = 1'b1;
  endtask

  task t_drain;
    cfg(6'h00, 7'h00, 3'h0, 4'h0, 1'b0, 1'b0);
    wbe = 1'b0;
    pe = 1'b0;
    dec = 4'b0011;
    wait_n(1);
    dec = '0;
    wait_n(2);
    `CHK("hold_exempt", 1'b0, ctl.issue_hold);
    dec = 4'b0010;
    wait_n(1);
    dec = '0;
    wait_n(5);
    `CHK("hold_busy", 1'b1, ctl.issue_hold);
    wbe = 1'b1;
    pe = 1'b1;
    wait_n(3);
    `CHK("hold_done", 1'b0, ctl.issue_hold);
    cfg(6'h00, 7'h04, 3'h0, 4'h0, 1'b0, 1'b0);
    wbe = 1'b0;
    pe = 1'b0;
    dec = 4'b0010;
    wait_n(1);
    dec = '0;
    wait_n(3);
    `CHK("hold_piped", 1'b0, ctl.issue_hold);
    wbe = 1'b1;
    pe = 1'b1;
  endtask

  task t_hold;
    itb_acc = 1'b1;
    entry = 64'h0123456789ABCDEF;
    wait_n(1);
    itb_acc = 1'b0;
    ipr(1'b0, 5'h03, '0, q);
    `CHK("hold_first", 64'h0123456789ABCDEF, q);
    itb_acc = 1'b1;
    entry = 64'hFEDCBA9876543210;
    wait_n(1);
    itb_acc = 1'b0;
    ipr(1'b0, 5'h03, '0, q);
    `CHK("hold_second", 64'hFEDCBA9876543210, q);
  endtask

  // n events; the last one overflows, request follows six cycles later
  task automatic ovf(input ibc_pkg::ibc_evt_t e, input int n, input int b);
    repeat (n)
    begin
      evt = e;
      @(negedge clk);
    end
    evt = '0;
    wait_n(4);
    `CHK("irq_early", 1'b0, irq[b]);
    if (e.icache_miss) `CHK("no_complete", 1'b1, ctl.no_complete);
    wait_n(1);
    `CHK("irq_on_time", 1'b1, irq[b]);
    wait_n(3);
    `CHK("irq_stands", 1'b1, irq[b]);
    ack[b] = 1'b1;
    wait_n(1);
    ack = '0;
    `CHK("irq_acked", 1'b0, irq[b]);
  endtask

  task automatic t_count;
    ibc_pkg::ibc_evt_t e;
    int n;
    fv = 1'b1;
    vpc = 43'h1ABCDEF0123;
    cfg(6'h00, 7'h00, 3'h1, 4'h4, 1'b1, 1'b1);
    e = '0;
    e.icache_miss = 1'b1;
    ovf(e, 256, 1);
    ovf(e, 256, 1);
    `CHK("miss_pc", 43'h1ABCDEF0123, mpc);
    cfg(6'h00, 7'h00, 3'h1, 4'h4, 1'b0, 1'b1);
    ovf(e, 3584, 1);
    e = '0;
    e.load = 1'b1;
    ovf(e, 4096, 0);
    cfg(6'h00, 7'h00, 3'h1, 4'h0, 1'b1, 1'b1);
    e = '0;
    e.issue_cnt = 2'h2;
    ovf(e, 4096, 0);
    cfg(6'h00, 7'h00, 3'h7, 4'h0, 1'b1, 1'b1);
    ext_pin = 1'b1;
    n = 0;
    // 256 samples at one per two cycles, plus sync and request delay
    while (irq[1] !== 1'b1 && n < 700)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("ext_cycles", 1'b1, (n >= 500 && n <= 530));
    ext_pin = 1'b0;
    // total-cycle selection: counter 0 sits at a multiple of 2^12 here
    cfg(6'h00, 7'h00, 3'h7, 4'hA, 1'b1, 1'b1);
    n = 0;
    while (irq[0] !== 1'b1 && n < 4200)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("cycle_count", 4098, n);
    fv = 1'b0;
  endtask

  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    t_reset;
    t_format;
    t_enables;
    t_fetch;
    t_drain;
    t_hold;
    t_count;
    give_verdict;
  end
endmodule
